//--- cmh_pkg.sv
// constants, field positions and object layout of the can message handler
package cmh_pkg;

	// ------------------------------------------------------------
	// sizes and timing
	// ------------------------------------------------------------
	localparam int unsigned MAX_OBJ = 32;
	localparam logic [3:0] IDLE_BITS = 4'hB;
	localparam logic CTL_HALT_RST = 1'b1;

	// ------------------------------------------------------------
	// byte offsets on the register bus
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CTL = 8'h00;
	localparam logic [7:0] OFF_TXREQ = 8'h04;
	localparam logic [7:0] OFF_NEWDATA = 8'h08;
	localparam logic [7:0] OFF_IRQPEND = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_SET_ONE = 8'h40;
	localparam logic [7:0] OFF_SET_TWO = 8'h80;
	localparam logic [5:0] OFF_XFER_SEL = 6'h00;
	localparam logic [5:0] OFF_CMD_REQ = 6'h04;
	localparam logic [5:0] OFF_MASK_LO = 6'h08;
	localparam logic [5:0] OFF_MASK_HI = 6'h0C;
	localparam logic [5:0] OFF_ID_LO = 6'h10;
	localparam logic [5:0] OFF_ID_HI = 6'h14;
	localparam logic [5:0] OFF_OBJ_CTL = 6'h18;
	localparam logic [5:0] OFF_PAYLOAD = 6'h1C;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTL_HALT = 0;
	localparam int CM_WRITE = 7;
	localparam int CM_MASK_SEL = 6;
	localparam int CM_ID_SEL = 5;
	localparam int CM_CTRL_SEL = 4;
	localparam int CM_CLR_PEND = 3;
	localparam int CM_NEW_DATA = 2;
	localparam int CM_DATA_A = 1;
	localparam int CM_DATA_B = 0;
	localparam int CRQ_BUSY = 15;
	localparam int MH_EXT = 15;
	localparam int MH_SENSE = 14;
	localparam int IH_VALID = 15;
	localparam int IH_EXT = 14;
	localparam int IH_SENSE = 13;
	localparam int OC_NEW = 15;
	localparam int OC_LOST = 14;
	localparam int OC_PEND = 13;
	localparam int OC_USE_MASK_BIT = 12;
	localparam int OC_TX_IRQ_ENABLE = 11;
	localparam int OC_RXIE = 10;
	localparam int OC_REMOTE = 9;
	localparam int OC_TXREQ = 8;
	localparam int OC_EOB = 7;

	// one message object in the message ram
	typedef struct packed {
		logic [28:0] mask;
		logic mask_ext;
		logic mask_sense;
		logic [28:0] id;
		logic ext_id;
		logic sense;
		logic valid;
		logic new_data;
		logic msg_lost;
		logic irq_pend;
		logic use_mask;
		logic tx_ie;
		logic rx_ie;
		logic remote_en;
		logic tx_req;
		logic end_buf;
		logic [3:0] dlc;
		logic [63:0] data;
	} cmh_obj_s;

	// one interface register set
	typedef struct packed {
		logic [7:0] xfer_sel;
		logic busy;
		logic [5:0] obj_num;
		logic [15:0] mask_lo;
		logic [15:0] mask_hi;
		logic [15:0] id_lo;
		logic [15:0] id_hi;
		logic [15:0] obj_ctl;
		logic [3:0][15:0] payload;
	} cmh_ifc_s;

endpackage

//--- cmh_message_handler.sv
// message handler: message ram, two interface sets, filtering and tx scheduling
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - two identical interface sets, each queues one ram transfer independently.
// - clearing halt lets the block sync to the bus, then transfer messages.
// - accepted data frame stores all id bits, length code and eight data bytes.
// - masked-out id bits are overwritten by the received identifier.
// - all ram accesses of one cycle applied in fixed order, nothing torn.
// - a transmit request from software sets both request and new data flags.
// - pending objects are sent lowest object number first.
// - updating a pending object before its load sends the new contents.
// - remote frame hitting a remote-enabled object sets its transmit request.
// - with use-mask set the mask widens which remote frames hit the object.
// - load only when engine ready and no interface transfer is active.
// - loading an object into the shift register clears its new data flag.
// - success clears the request only if no new data arrived meanwhile.
// - with tx interrupt enable, success sets the object's pending flag.
// - failed frames stay pending and are re-picked by priority later.
// - transfer select gives direction and which object fields move.
// - mask low covers id 15..0, mask high 28..16 or standard 10..0.
// - identifier low and high registers map id bits like the mask.
// - first frame byte sits in bits 7..0 of the first payload register.
// - writing object number to command request starts the transfer.
// - halt stops reception and loads (interface transfers still run), holds tx high, bus-off sets halt.
// - after halt clears, wait for eleven recessive bits before joining.
// - message ram holds NUM_OBJ (at most thirty-two) identical objects, reached only via sets.
module cmh_message_handler #(
	parameter int unsigned NUM_OBJ = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic bus_off_i,
	input wire logic bit_tick_i,
	input wire logic rx_bit_i,
	input wire logic eng_tx_i,
	output logic can_tx_o,
	output logic engine_run_o,
	input wire logic rx_valid_i,
	input wire logic [28:0] rx_id_i,
	input wire logic rx_ext_i,
	input wire logic rx_remote_i,
	input wire logic [3:0] rx_dlc_i,
	input wire logic [63:0] rx_data_i,
	input wire logic tx_ready_i,
	output logic tx_load_o,
	output logic [28:0] tx_id_o,
	output logic tx_ext_o,
	output logic tx_remote_o,
	output logic [3:0] tx_dlc_o,
	output logic [63:0] tx_data_o,
	input wire logic tx_done_i,
	input wire logic tx_ok_i
);
	import cmh_pkg::*;

	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	if (NUM_OBJ < 1 || NUM_OBJ > MAX_OBJ) begin : g_bad_num
		$error("NUM_OBJ must lie between 1 and 32");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		cmh_obj_s [NUM_OBJ-1:0] obj;
		cmh_ifc_s [1:0] ifc;
		logic halt;
		logic synced;
		logic [3:0] idle_cnt;
		logic inflight;
		logic [4:0] cur_obj;
		logic dirty;
		logic ack;
		logic [31:0] rdat;
		logic tx_pin;
		logic tx_load;
		logic [28:0] tx_id;
		logic tx_ext;
		logic tx_remote;
		logic [3:0] tx_dlc;
		logic [63:0] tx_data;
	} cmh_state_s;

	cmh_state_s state_reg;
	cmh_state_s state_next;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(logic [15:0] old, logic [31:0] wd, logic [3:0] sel);
		logic [15:0] v;
		v = old;
		if (sel[0]) v[7:0] = wd[7:0];
		if (sel[1]) v[15:8] = wd[15:8];
		return v;
	endfunction

	// lowest set bit wins: {found, index}
	function automatic logic [5:0] pick_first(logic [MAX_OBJ-1:0] v);
		logic [5:0] p;
		p = 6'h00;
		for (int i = MAX_OBJ - 1; i >= 0; i--) begin
			if (v[i]) p = {1'b1, 5'(i)};
		end
		return p;
	endfunction

	// acceptance filter of one object
	function automatic logic obj_hit(cmh_obj_s o, logic [28:0] id, logic ext, logic remote);
		logic [28:0] m;
		logic chk_ext;
		logic chk_sense;
		m = o.use_mask ? o.mask : {29{1'b1}};
		chk_ext = o.use_mask ? o.mask_ext : 1'b1;
		chk_sense = o.use_mask ? o.mask_sense : 1'b1;
		if (!ext) m[17:0] = 18'h00000; // standard id lives in bits 28..18
		return o.valid && (((o.id ^ id) & m) == 29'h00000000)
			&& (!chk_ext || (o.ext_id == ext)) && (!chk_sense || (o.sense == remote));
	endfunction

	// object control word as seen in an interface set
	function automatic logic [15:0] ctl_pack(cmh_obj_s o);
		return {o.new_data, o.msg_lost, o.irq_pend, o.use_mask, o.tx_ie, o.rx_ie,
			o.remote_en, o.tx_req, o.end_buf, 3'h0, o.dlc};
	endfunction

	// read of one interface set register
	function automatic logic [15:0] ifc_read(cmh_ifc_s f, logic [5:0] off);
		logic [15:0] v;
		v = 16'h0000;
		case (off)
			OFF_XFER_SEL: v = {8'h00, f.xfer_sel};
			OFF_CMD_REQ: v = {f.busy, 9'h000, f.obj_num};
			OFF_MASK_LO: v = f.mask_lo;
			OFF_MASK_HI: v = f.mask_hi;
			OFF_ID_LO: v = f.id_lo;
			OFF_ID_HI: v = f.id_hi;
			OFF_OBJ_CTL: v = f.obj_ctl;
			OFF_PAYLOAD: v = f.payload[0];
			OFF_PAYLOAD + 6'h04: v = f.payload[1];
			OFF_PAYLOAD + 6'h08: v = f.payload[2];
			OFF_PAYLOAD + 6'h0C: v = f.payload[3];
			default: v = 16'h0000;
		endcase
		return v;
	endfunction

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		logic wb_req;
		logic active;
		logic [1:0] set_hit;
		logic [MAX_OBJ-1:0] v_req;
		logic [MAX_OBJ-1:0] v_new;
		logic [MAX_OBJ-1:0] v_pend;
		logic [MAX_OBJ-1:0] v_hit;
		logic [5:0] pick;
		logic [4:0] idx;
		logic [7:0] cm;
		cmh_obj_s o;
		cmh_ifc_s f;
		wb_req = 1'b0;
		active = 1'b0;
		set_hit = 2'b00;
		v_req = '0;
		v_new = '0;
		v_pend = '0;
		v_hit = '0;
		pick = 6'h00;
		idx = 5'h00;
		cm = 8'h00;
		o = '0;
		f = '0;
		state_next = state_reg;
		state_next.tx_load = 1'b0;
		active = !state_reg.halt && state_reg.synced;
		for (int i = 0; i < NUM_OBJ; i++) begin
			v_req[i] = state_reg.obj[i].tx_req;
			v_new[i] = state_reg.obj[i].new_data;
			v_pend[i] = state_reg.obj[i].irq_pend;
		end

		// wishbone slave, answers every access one cycle later
		wb_req = wb_cyc_i && wb_stb_i && !state_reg.ack;
		state_next.ack = wb_req;
		set_hit[0] = wb_adr_i[7:6] == OFF_SET_ONE[7:6];
		set_hit[1] = wb_adr_i[7:6] == OFF_SET_TWO[7:6];
		if (wb_req && !wb_we_i) begin
			state_next.rdat = 32'h00000000;
			case (wb_adr_i)
				OFF_CTL: state_next.rdat = {31'h0, state_reg.halt};
				OFF_TXREQ: state_next.rdat = 32'(v_req);
				OFF_NEWDATA: state_next.rdat = 32'(v_new);
				OFF_IRQPEND: state_next.rdat = 32'(v_pend);
				OFF_STATUS: state_next.rdat = {31'h0, active};
				default: begin
					for (int k = 0; k < 2; k++) begin
						if (set_hit[k]) begin
							state_next.rdat = {16'h0000, ifc_read(state_reg.ifc[k], wb_adr_i[5:0])};
						end
					end
				end
			endcase
		end
		if (wb_req && wb_we_i) begin
			if (wb_adr_i == OFF_CTL && wb_sel_i[0]) begin
				state_next.halt = wb_dat_i[CTL_HALT];
			end
			for (int k = 0; k < 2; k++) begin
				f = state_next.ifc[k];
				if (set_hit[k] && !f.busy) begin
					case (wb_adr_i[5:0])
						OFF_XFER_SEL: if (wb_sel_i[0]) f.xfer_sel = wb_dat_i[7:0];
						OFF_CMD_REQ: begin
							if (wb_sel_i[0] && wb_dat_i[5:0] != 6'h00
								&& 32'(wb_dat_i[5:0]) <= NUM_OBJ) begin
								f.obj_num = wb_dat_i[5:0];
								f.busy = 1'b1;
							end
						end
						OFF_MASK_LO: f.mask_lo = merge16(f.mask_lo, wb_dat_i, wb_sel_i);
						OFF_MASK_HI: f.mask_hi = merge16(f.mask_hi, wb_dat_i, wb_sel_i);
						OFF_ID_LO: f.id_lo = merge16(f.id_lo, wb_dat_i, wb_sel_i);
						OFF_ID_HI: f.id_hi = merge16(f.id_hi, wb_dat_i, wb_sel_i);
						OFF_OBJ_CTL: f.obj_ctl = merge16(f.obj_ctl, wb_dat_i, wb_sel_i);
						OFF_PAYLOAD: f.payload[0] = merge16(f.payload[0], wb_dat_i, wb_sel_i);
						OFF_PAYLOAD + 6'h04: f.payload[1] = merge16(f.payload[1], wb_dat_i, wb_sel_i);
						OFF_PAYLOAD + 6'h08: f.payload[2] = merge16(f.payload[2], wb_dat_i, wb_sel_i);
						OFF_PAYLOAD + 6'h0C: f.payload[3] = merge16(f.payload[3], wb_dat_i, wb_sel_i);
						default: f = state_next.ifc[k];
					endcase
				end
				state_next.ifc[k] = f;
			end
		end

		// interface-to-ram transfers, set one before set two
		for (int k = 0; k < 2; k++) begin
			f = state_next.ifc[k];
			if (state_reg.ifc[k].busy) begin
				cm = f.xfer_sel;
				idx = 5'(f.obj_num - 6'h01);
				o = state_next.obj[idx];
				if (cm[CM_WRITE]) begin
					if (cm[CM_MASK_SEL]) begin
						o.mask = {f.mask_hi[12:0], f.mask_lo};
						o.mask_ext = f.mask_hi[MH_EXT];
						o.mask_sense = f.mask_hi[MH_SENSE];
					end
					if (cm[CM_ID_SEL]) begin
						o.id = {f.id_hi[12:0], f.id_lo};
						o.ext_id = f.id_hi[IH_EXT];
						o.sense = f.id_hi[IH_SENSE];
						o.valid = f.id_hi[IH_VALID];
					end
					if (cm[CM_CTRL_SEL]) begin
						o.new_data = f.obj_ctl[OC_NEW];
						o.msg_lost = f.obj_ctl[OC_LOST];
						o.irq_pend = f.obj_ctl[OC_PEND];
						o.use_mask = f.obj_ctl[OC_USE_MASK_BIT];
						o.tx_ie = f.obj_ctl[OC_TX_IRQ_ENABLE];
						o.rx_ie = f.obj_ctl[OC_RXIE];
						o.remote_en = f.obj_ctl[OC_REMOTE];
						o.tx_req = f.obj_ctl[OC_TXREQ];
						o.end_buf = f.obj_ctl[OC_EOB];
						o.dlc = f.obj_ctl[3:0];
					end
					if (cm[CM_DATA_A]) o.data[31:0] = {f.payload[1], f.payload[0]};
					if (cm[CM_DATA_B]) o.data[63:32] = {f.payload[3], f.payload[2]};
					if (cm[CM_NEW_DATA]) begin
						o.tx_req = 1'b1;
						o.new_data = 1'b1;
					end
					if (state_reg.inflight && idx == state_reg.cur_obj
						&& (cm[CM_DATA_A] || cm[CM_DATA_B] || cm[CM_CTRL_SEL])) begin
						state_next.dirty = 1'b1;
					end
				end else begin
					if (cm[CM_MASK_SEL]) begin
						f.mask_lo = o.mask[15:0];
						f.mask_hi = {o.mask_ext, o.mask_sense, 1'b0, o.mask[28:16]};
					end
					if (cm[CM_ID_SEL]) begin
						f.id_lo = o.id[15:0];
						f.id_hi = {o.valid, o.ext_id, o.sense, o.id[28:16]};
					end
					if (cm[CM_CTRL_SEL]) f.obj_ctl = ctl_pack(o);
					if (cm[CM_DATA_A]) f.payload[1:0] = o.data[31:0];
					if (cm[CM_DATA_B]) f.payload[3:2] = o.data[63:32];
					if (cm[CM_NEW_DATA]) o.new_data = 1'b0;
				end
				if (cm[CM_CLR_PEND]) o.irq_pend = 1'b0;
				state_next.obj[idx] = o;
				f.busy = 1'b0;
			end
			state_next.ifc[k] = f;
		end

		// end of a transmission from the engine
		if (state_reg.inflight && tx_done_i) begin
			state_next.inflight = 1'b0;
			o = state_next.obj[state_reg.cur_obj];
			if (tx_ok_i) begin
				if (!state_next.dirty && !o.new_data) o.tx_req = 1'b0;
				if (o.tx_ie) o.irq_pend = 1'b1;
			end
			state_next.obj[state_reg.cur_obj] = o;
		end

		// received frame: first matching object from object 1 upward
		if (active && rx_valid_i) begin
			for (int i = 0; i < NUM_OBJ; i++) begin
				v_hit[i] = obj_hit(state_next.obj[i], rx_id_i, rx_ext_i, rx_remote_i);
			end
			pick = pick_first(v_hit);
			if (pick[5]) begin
				o = state_next.obj[pick[4:0]];
				if (!rx_remote_i) begin
					o.id = rx_id_i;
					o.ext_id = rx_ext_i;
					o.dlc = rx_dlc_i;
					o.data = rx_data_i;
					o.msg_lost = o.msg_lost | o.new_data;
					o.new_data = 1'b1;
					if (o.rx_ie) o.irq_pend = 1'b1;
				end else if (o.remote_en) begin
					o.tx_req = 1'b1;
				end
				state_next.obj[pick[4:0]] = o;
			end
		end

		// load the highest-priority pending object into the shift register
		if (active && tx_ready_i && !state_next.inflight && !state_reg.inflight
			&& !state_reg.ifc[0].busy && !state_reg.ifc[1].busy) begin
			v_req = '0;
			for (int i = 0; i < NUM_OBJ; i++) begin
				v_req[i] = state_next.obj[i].valid && state_next.obj[i].tx_req;
			end
			pick = pick_first(v_req);
			if (pick[5]) begin
				o = state_next.obj[pick[4:0]];
				state_next.tx_load = 1'b1;
				state_next.tx_id = o.id;
				state_next.tx_ext = o.ext_id;
				state_next.tx_remote = !o.sense;
				state_next.tx_dlc = o.dlc;
				state_next.tx_data = o.data;
				state_next.inflight = 1'b1;
				state_next.cur_obj = pick[4:0];
				state_next.dirty = 1'b0;
				o.new_data = 1'b0;
				state_next.obj[pick[4:0]] = o;
			end
		end

		// halt, bus-off and idle-bus synchronisation
		if (bus_off_i) state_next.halt = 1'b1;
		if (state_next.halt) begin
			state_next.synced = 1'b0;
			state_next.idle_cnt = 4'h0;
			state_next.inflight = 1'b0;
			state_next.tx_load = 1'b0;
		end else if (!state_reg.synced && bit_tick_i) begin
			if (!rx_bit_i) begin
				state_next.idle_cnt = 4'h0;
			end else if (state_reg.idle_cnt == IDLE_BITS - 4'h1) begin
				state_next.synced = 1'b1;
			end else begin
				state_next.idle_cnt = state_reg.idle_cnt + 4'h1;
			end
		end
		state_next.tx_pin = state_next.halt ? 1'b1 : eng_tx_i;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= '0;
			state_reg.halt <= CTL_HALT_RST;
			state_reg.tx_pin <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs
	assign wb_dat_o = state_reg.rdat;
	assign wb_ack_o = state_reg.ack;
	assign can_tx_o = state_reg.tx_pin;
	assign engine_run_o = !state_reg.halt && state_reg.synced;
	assign tx_load_o = state_reg.tx_load;
	assign tx_id_o = state_reg.tx_id;
	assign tx_ext_o = state_reg.tx_ext;
	assign tx_remote_o = state_reg.tx_remote;
	assign tx_dlc_o = state_reg.tx_dlc;
	assign tx_data_o = state_reg.tx_data;

endmodule

`default_nettype wire

//--- cmh_message_handler_asserts.sv
// concurrent checks on the ports of the can message handler
`timescale 1ns/1ns
`default_nettype none
module cmh_message_handler_asserts
	import cmh_pkg::*;
#(
	parameter int unsigned NUM_OBJ = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic bus_off_i,
	input wire logic bit_tick_i,
	input wire logic rx_bit_i,
	input wire logic eng_tx_i,
	input wire logic can_tx_o,
	input wire logic engine_run_o,
	input wire logic tx_ready_i,
	input wire logic tx_load_o
);
	import cmh_pkg::*;
	// ---------------------------------------------
	// helper logic
	// ---------------------------------------------
	logic [3:0] idle_cnt_reg;
	logic take, halt_clr, cmd_wr;
	// decoded bus writes
	assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign halt_clr = take && wb_adr_i == OFF_CTL && wb_sel_i[0] && !wb_dat_i[0];
	assign cmd_wr = take && (wb_adr_i == (OFF_SET_ONE | {2'b00, OFF_CMD_REQ})
		|| wb_adr_i == (OFF_SET_TWO | {2'b00, OFF_CMD_REQ}));
	// consecutive recessive bit times since halt was last cleared, saturating
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idle_cnt_reg <= 4'h0;
		end else if (halt_clr) begin
			idle_cnt_reg <= {3'h0, bit_tick_i && rx_bit_i}; // tick in the clearing cycle counts
		end else if (bit_tick_i) begin
			idle_cnt_reg <= !rx_bit_i ? 4'h0 : (idle_cnt_reg == 4'hF ? 4'hF : idle_cnt_reg + 4'h1);
		end
	end
	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_busoff_halt: assert property (bus_off_i |=> ##1 (can_tx_o && !engine_run_o))
		else $error("bus off did not halt with tx high");
	chk_tx_follow: assert property (engine_run_o && $past(engine_run_o) |-> can_tx_o == $past(eng_tx_i))
		else $error("tx pin not following engine");
	chk_load_cond: assert property (tx_load_o |-> $past(tx_ready_i) && $past(engine_run_o))
		else $error("load while shift register not ready");
	chk_load_pulse: assert property (tx_load_o |=> !tx_load_o)
		else $error("load pulse too long");
	chk_load_busy: assert property (cmd_wr |=> ##1 !tx_load_o)
		else $error("load during ram transfer");
	chk_sync_idle: assert property ($rose(engine_run_o) |-> idle_cnt_reg >= 4'hB)
		else $error("joined bus before eleven recessive bits");
endmodule
bind cmh_message_handler cmh_message_handler_asserts #(.NUM_OBJ(NUM_OBJ)) cmh_chk_inst (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
	.bus_off_i(bus_off_i), .bit_tick_i(bit_tick_i), .rx_bit_i(rx_bit_i), .eng_tx_i(eng_tx_i),
	.can_tx_o(can_tx_o), .engine_run_o(engine_run_o), .tx_ready_i(tx_ready_i),
	.tx_load_o(tx_load_o));
`default_nettype wire

//--- cmh_engine_model.sv
// behavioural model of the bit level protocol engine beside the handler
`timescale 1ns/1ns
`default_nettype none
module cmh_engine_model #(
	parameter logic [5:0] FRAME = 6'h28
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic stall_i,
	input wire logic fail_i,
	input wire logic tx_load_i,
	output logic bit_tick_o,
	output logic rx_bit_o,
	output logic eng_tx_o,
	output logic tx_ready_o,
	output logic tx_done_o,
	output logic tx_ok_o
);
	logic [1:0] div;
	logic [5:0] left;
	logic bad;
	// frame timer, outcome latched at load so a failure hits one frame only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div <= 2'h0;
			left <= 6'h0;
			bad <= 1'b0;
			tx_done_o <= 1'b0;
			tx_ok_o <= 1'b0;
			eng_tx_o <= 1'b1;
		end else begin
			div <= div + 2'h1;
			tx_done_o <= left == 6'h01;
			tx_ok_o <= left == 6'h01 && !bad;
			eng_tx_o <= left != 6'h0 ? div[0] : 1'b1;
			if (tx_load_i) begin
				left <= FRAME;
				bad <= fail_i;
			end else if (left != 6'h0) begin
				left <= left - 6'h1;
			end
		end
	end
	// one bit time every four clocks, bus idle reads recessive
	assign bit_tick_o = div == 2'h3;
	assign rx_bit_o = 1'b1;
	assign tx_ready_o = left == 6'h0 && !stall_i;
endmodule
`default_nettype wire

//--- tb.sv
// self-checking testbench of the can message handler
`timescale 1ns/1ns
`default_nettype none
module tb;
	import cmh_pkg::*;
	localparam logic [7:0] S1 = OFF_SET_ONE;
	localparam logic [7:0] S2 = OFF_SET_TWO;
	logic clk_i, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0, rx_dlc_i = 4'h0, tx_dlc_o;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic bus_off_i = 1'b0, rx_valid_i = 1'b0, rx_ext_i = 1'b0, rx_remote_i = 1'b0;
	logic stall = 1'b1, fail = 1'b0;
	logic [28:0] rx_id_i = 29'h0, tx_id_o;
	logic [63:0] rx_data_i = 64'h0, tx_data_o;
	logic wb_ack_o, can_tx_o, engine_run_o, tx_load_o, tx_ext_o, tx_remote_o;
	logic bit_tick_i, rx_bit_i, eng_tx_i, tx_ready_i, tx_done_i, tx_ok_i;
	int bad_count = 0, num_checks = 0, cyc_count = 0;

	cmh_message_handler #(.NUM_OBJ(32)) cmh_message_handler_inst (.*);
	cmh_engine_model cmh_engine_model_inst (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
		.fail_i(fail), .tx_load_i(tx_load_o), .bit_tick_o(bit_tick_i), .rx_bit_o(rx_bit_i),
		.eng_tx_o(eng_tx_i), .tx_ready_o(tx_ready_i), .tx_done_o(tx_done_i), .tx_ok_o(tx_ok_i));

	// ---------------------------------------------
	// tasks
	// ---------------------------------------------
	// classic single wishbone cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("BAD time=%0t seen=%h expected=%h", $time, s, e);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		chk({32'h0, r}, {32'h0, e});
	endtask
	// four payload words, word i carries d + i
	task automatic pay(input logic [7:0] b, input logic [15:0] d);
		logic [31:0] r;
		for (int i = 0; i < 4; i++) wb(1'b1, b + {2'b00, OFF_PAYLOAD} + 8'(4 * i), {16'h0, d + 16'(i)}, r);
	endtask
	task automatic go(input logic [7:0] b, input logic [7:0] s, input logic [5:0] n);
		logic [31:0] r;
		wb(1'b1, b + {2'b00, OFF_XFER_SEL}, {24'h0, s}, r);
		wb(1'b1, b + {2'b00, OFF_CMD_REQ}, {26'h0, n}, r);
	endtask
	task automatic put(input logic [7:0] b, input logic [5:0] n, input logic [15:0] ihi, ilo,
		ctl, mlo, mhi, d);
		logic [31:0] r;
		wb(1'b1, b + {2'b00, OFF_MASK_LO}, {16'h0, mlo}, r);
		wb(1'b1, b + {2'b00, OFF_MASK_HI}, {16'h0, mhi}, r);
		wb(1'b1, b + {2'b00, OFF_ID_LO}, {16'h0, ilo}, r);
		wb(1'b1, b + {2'b00, OFF_ID_HI}, {16'h0, ihi}, r);
		wb(1'b1, b + {2'b00, OFF_OBJ_CTL}, {16'h0, ctl}, r);
		pay(b, d);
		go(b, 8'hF3, n);
	endtask
	// transmit objects n carry extended id {n, 0x1000 + n}
	task automatic wait_load(input logic [5:0] n);
		do @(posedge clk_i); while (tx_load_o !== 1'b1);
		chk({35'h0, tx_id_o}, {35'h0, 7'h0, n, 16'h1000 | {10'h0, n}});
		chk({58'h0, tx_ext_o, tx_remote_o, tx_dlc_o}, {58'h0, 1'b1, 1'b0, 4'h8});
	endtask
	task automatic wait_done;
		do @(posedge clk_i); while (tx_done_i !== 1'b1);
	endtask
	task automatic frame(input logic [28:0] id, input logic rmt);
		@(posedge clk_i);
		rx_valid_i <= 1'b1;
		rx_id_i <= id;
		rx_ext_i <= 1'b1;
		rx_remote_i <= rmt;
		rx_dlc_i <= 4'h8;
		rx_data_i <= 64'h8877665544332211;
		@(posedge clk_i);
		rx_valid_i <= 1'b0;
		rx_id_i <= ~id;
		rx_data_i <= ~rx_data_i;
	endtask
	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ---------------------------------------------
	// clock and watchdog
	// ---------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc_count++;
		if (cyc_count == 20000) begin
			bad_count++;
			print_verdict();
		end
	end

	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(OFF_CTL, 32'h1);
		rd(OFF_TXREQ, 32'h0);
		rd(8'hFC, 32'h0);
		wb(1'b1, OFF_CTL, 32'h0, q);
		do @(posedge clk_i); while (engine_run_o !== 1'b1);
		rd(OFF_STATUS, 32'h1);
		// priority, update before load, flags
		put(S1, 6'h02, 16'hE002, 16'h1002, 16'h0888, 16'h0, 16'h0, 16'h1111);
		put(S2, 6'h03, 16'hE003, 16'h1003, 16'h0008, 16'h0, 16'h0, 16'h3330);
		put(S1, 6'h05, 16'hE005, 16'h1005, 16'h0008, 16'h0, 16'h0, 16'h5550);
		pay(S1, 16'h2211);
		go(S1, 8'h83, 6'h02);
		go(S1, 8'h84, 6'h02);
		go(S2, 8'h84, 6'h05);
		rd(OFF_TXREQ, 32'h12);
		rd(OFF_NEWDATA, 32'h12);
		stall <= 1'b0;
		wait_load(6'h02);
		chk(tx_data_o, 64'h2214221322122211);
		rd(OFF_NEWDATA, 32'h10);
		wait_load(6'h05);
		rd(OFF_TXREQ, 32'h10);
		rd(OFF_IRQPEND, 32'h02);
		// failed frame gives way to a higher priority request
		wait_done();
		fail <= 1'b1;
		go(S1, 8'h84, 6'h05);
		wait_load(6'h05);
		fail <= 1'b0;
		go(S2, 8'h84, 6'h03);
		wait_load(6'h03);
		wait_load(6'h05);
		wait_done();
		rd(OFF_TXREQ, 32'h0);
		// masked data frame reception into object 7
		put(S2, 6'h07, 16'hC007, 16'h0070, 16'h1000, 16'hFF00, 16'h9FFF, 16'h0);
		frame({13'h0007, 16'h0075}, 1'b0);
		rd(OFF_NEWDATA, 32'h40);
		go(S2, 8'h77, 6'h07);
		rd(S2 + {2'b00, OFF_ID_LO}, 32'h0075);
		rd(S2 + {2'b00, OFF_ID_HI}, 32'hC007);
		wb(1'b0, S2 + {2'b00, OFF_OBJ_CTL}, 32'h0, q);
		chk({48'h0, q[15:0]}, 64'h9008);
		rd(S2 + {2'b00, OFF_PAYLOAD}, 32'h2211);
		rd(S2 + {2'b00, OFF_PAYLOAD} + 8'h0C, 32'h8877);
		rd(OFF_NEWDATA, 32'h0);
		// remote frame triggers object 9
		put(S1, 6'h09, 16'hE009, 16'h1009, 16'h1208, 16'hFFFF, 16'h9FFF, 16'h9990);
		frame({13'h0009, 16'h1009}, 1'b1);
		wait_load(6'h09);
		wait_done();
		// bus off forces halt
		bus_off_i <= 1'b1;
		@(posedge clk_i);
		bus_off_i <= 1'b0;
		rd(OFF_CTL, 32'h1);
		rd(OFF_STATUS, 32'h0);
		chk({63'h0, can_tx_o}, 64'h1);
		print_verdict();
	end
endmodule
`default_nettype wire
